/* File: include/pmvtr_defines.svh */
/*
  Constants of the program store, vector and table-read block: register
  offsets, reset values, entry addresses and field positions.
  Assumes inclusion by bare name from the package and the design modules.
*/
// Summary of operation
// - program store holds 16K words of 16 bits, addressed by the program counter.
// - after reset the program counter starts at address 000H.
// - enabled external interrupt 0 edge jumps to 004H when stack not full.
// - enabled external interrupt 1 edge jumps to 008H when stack not full.
// - enabled timer 0 overflow jumps to 00CH when stack not full.
// - enabled timer 1 overflow jumps to 010H when stack not full.
// - enabled serial interface request jumps to 014H when stack not full.
// - enabled shared sources (six of them) jump to 018H when stack not full.
// - writable 8-bit table pointer gives low address bits of every table read.
// - current-page read takes bits 13..8 from PC; last-page read forces ones.
// - table read writes low byte of the word to the named data register.
// - high byte goes to read-only high-byte register; unused bits read zero.
// - high-byte register ignores writes; only table reads change it.
// - each table read takes two instruction cycles.
// - acknowledge pushes the program counter before loading the vector.
// - with stack full the flag stays set, no acknowledge, serviced after a pop.
`ifndef PMVTR_DEFINES_SVH
`define PMVTR_DEFINES_SVH

// sizes
`define PMVTR_ADDR_W 14
`define PMVTR_WORD_W 16
`define PMVTR_DEPTH 16384
`define PMVTR_NUM_VEC 6
`define PMVTR_NUM_MF 6
`define PMVTR_NUM_PIN 3

// register byte offsets
`define PMVTR_OFS_TBL_PTR 4'h0
`define PMVTR_OFS_TBL_HIGH 4'h4
`define PMVTR_OFS_STATUS 4'h8

// reset values
`define PMVTR_RST_TBL_PTR 8'h00
`define PMVTR_RST_TBL_HIGH 8'h00
`define PMVTR_RST_PC 14'h0000

// entry addresses
`define PMVTR_VEC_EXT0 14'h0004
`define PMVTR_VEC_EXT1 14'h0008
`define PMVTR_VEC_TMR0 14'h000C
`define PMVTR_VEC_TMR1 14'h0010
`define PMVTR_VEC_SER 14'h0014
`define PMVTR_VEC_MULTI 14'h0018

// page bits forced for a last-page table read
`define PMVTR_LAST_PAGE 6'h3F

// status register fields
`define PMVTR_ST_PC_LSB 0
`define PMVTR_ST_REQ_LSB 16
`define PMVTR_ST_BUSY_BIT 24

`endif

/* File: include/pmvtr_pkg.sv */
/*
  Types of the program store, vector and table-read block.
  Assumes the defines header sits on the include path.
*/
`include "pmvtr_defines.svh"

package pmvtr_pkg;

  // table-read request from the instruction decoder
  typedef struct packed {
    logic cur;        // current-page read
    logic last;       // last-page read
    logic [7:0] dest; // data memory register address
  } pmvtr_tbl_req_t;

  // low-byte write towards data memory
  typedef struct packed {
    logic en;
    logic [7:0] addr;
    logic [7:0] data;
  } pmvtr_dm_wr_t;

  // return stack push
  typedef struct packed {
    logic push;
    logic [`PMVTR_ADDR_W-1:0] data;
  } pmvtr_push_t;

  // table-read sequencer
  typedef enum logic [1:0] {
    TS_IDLE = 2'b01,
    TS_XFER = 2'b10
  } pmvtr_tstate_t;

endpackage

/* File: rtl/pmvtr_prog_mem.sv */
/*
  Program store: 16K words of 16 bits, one write port for loading and one
  read port whose data come out of a register.
  Assumes the loading port is used only while the core is held idle.
*/
`include "pmvtr_defines.svh"
module pmvtr_prog_mem
  import pmvtr_pkg::*;
(
  input wire logic ref_clk,                          // instruction clock
  input wire logic wrEn,                             // load strobe
  input wire logic [`PMVTR_ADDR_W-1:0] wrAddr,       // load address
  input wire logic [`PMVTR_WORD_W-1:0] wrData,       // load word
  input wire logic [`PMVTR_ADDR_W-1:0] rdAddr,       // read address
  output logic [`PMVTR_WORD_W-1:0] rdData            // registered word
);

  logic [`PMVTR_WORD_W-1:0] mem [`PMVTR_DEPTH];

  // storage and registered read
  always_ff @(posedge ref_clk) begin
    if (wrEn) begin
      mem[wrAddr] <= wrData;
    end
    rdData <= mem[rdAddr];
  end

endmodule // pmvtr_prog_mem

/* File: rtl/pmvtr_vec_arb.sv */
/*
  Vector arbiter: picks the pending enabled request with the lowest entry
  address and gives its one-hot grant and its entry address.
  Assumes request bit 0 belongs to the lowest entry address.
*/
`include "pmvtr_defines.svh"
module pmvtr_vec_arb
  import pmvtr_pkg::*;
(
  input wire logic [`PMVTR_NUM_VEC-1:0] req,          // pending and enabled
  output logic [`PMVTR_NUM_VEC-1:0] grant,            // one-hot winner
  output logic [`PMVTR_ADDR_W-1:0] vector             // winner entry address
);

  localparam logic [`PMVTR_ADDR_W-1:0] VEC_TAB [`PMVTR_NUM_VEC] = '{
    `PMVTR_VEC_EXT0,
    `PMVTR_VEC_EXT1,
    `PMVTR_VEC_TMR0,
    `PMVTR_VEC_TMR1,
    `PMVTR_VEC_SER,
    `PMVTR_VEC_MULTI
  };

  logic [`PMVTR_NUM_VEC:0] lower;
  logic [`PMVTR_ADDR_W-1:0] part [`PMVTR_NUM_VEC+1];

  assign lower[0] = 1'b0;
  assign part[0] = '0;

  // priority chain, lowest index first
  for (genvar i = 0; i < `PMVTR_NUM_VEC; i++) begin : g_prio
    assign grant[i] = req[i] & ~lower[i];
    assign lower[i+1] = lower[i] | req[i];
    assign part[i+1] = part[i] | (grant[i] ? VEC_TAB[i] : '0);
  end

  assign vector = part[`PMVTR_NUM_VEC];

endmodule // pmvtr_vec_arb

/* File: rtl/pmvtr_top.sv */
/*
  Program store with reset and interrupt entry, program counter, and the
  table-read path with its pointer and high-byte registers on Avalon-MM.
  Assumes the core decoder, the return stack and data memory sit outside,
  on the same clock; interrupt pins arrive asynchronously.
*/
`include "pmvtr_defines.svh"
module pmvtr_top
  import pmvtr_pkg::*;
(
  input wire logic ref_clk,                          // instruction clock
  input wire logic sys_rst,                          // async reset
  // avalon-mm slave
  input wire logic [3:0] avs_address,                // byte address
  input wire logic avs_read,                         // read request
  input wire logic avs_write,                        // write request
  input wire logic [31:0] avs_writedata,             // write data
  output logic [31:0] avs_readdata,                  // read data
  output logic avs_waitrequest,                      // stall
  // program loading
  input wire logic pgmWrEn,                          // load strobe
  input wire logic [`PMVTR_ADDR_W-1:0] pgmWrAddr,    // load address
  input wire logic [`PMVTR_WORD_W-1:0] pgmWrData,    // load word
  // core fetch and branch
  input wire logic coreAdvance,                      // step pc by one
  input wire logic coreBranch,                       // load pc
  input wire logic [`PMVTR_ADDR_W-1:0] coreBranchAddr, // branch target
  output logic [`PMVTR_ADDR_W-1:0] pc,               // program counter
  output logic [`PMVTR_WORD_W-1:0] instrWord,        // fetched word
  // table read
  input wire pmvtr_tbl_req_t tblReq,                 // read request
  output logic tblBusy,                              // second cycle
  output pmvtr_dm_wr_t dmWr,                         // low-byte write
  // interrupt sources
  input wire logic [1:0] extIntPin,                  // external pins
  input wire logic [1:0] extFallEdge,                // 1 selects falling
  input wire logic periphIntPin,                     // peripheral pin
  input wire logic tmr0Ovf,                          // timer 0 pulse
  input wire logic tmr1Ovf,                          // timer 1 pulse
  input wire logic serXfer,                          // serial pulse
  input wire logic [`PMVTR_NUM_MF-1:0] mfEvent,      // shared pulses
  input wire logic [`PMVTR_NUM_VEC-1:0] intEn,       // per-vector enable
  input wire logic [`PMVTR_NUM_MF-1:0] mfEn,         // shared enables
  input wire logic intAllowed,                       // boundary and master
  input wire logic stackFull,                        // return stack full
  output pmvtr_push_t stackPush,                     // push pc
  output logic intAck,                               // acknowledge pulse
  output logic [`PMVTR_NUM_VEC-1:0] intFlags,        // request flags
  output logic [`PMVTR_NUM_MF-1:0] mfFlags           // shared flags
);

  // ---------------------------------------------------------------
  // pin synchronisers and edge detection
  logic [`PMVTR_NUM_PIN-1:0] pinRaw;
  logic [`PMVTR_NUM_PIN-1:0] pinMeta_r;
  logic [`PMVTR_NUM_PIN-1:0] pinSync_r;
  logic [`PMVTR_NUM_PIN-1:0] pinPrev_r;
  logic [`PMVTR_NUM_PIN-1:0] pinRise;
  logic [`PMVTR_NUM_PIN-1:0] pinFall;

  assign pinRaw = {periphIntPin, extIntPin};

  // two flops per pin, then one for the edge
  for (genvar p = 0; p < `PMVTR_NUM_PIN; p++) begin : g_pin
    always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
        pinMeta_r[p] <= 1'b0;
        pinSync_r[p] <= 1'b0;
        pinPrev_r[p] <= 1'b0;
      end else begin
        pinMeta_r[p] <= pinRaw[p];
        pinSync_r[p] <= pinMeta_r[p];
        pinPrev_r[p] <= pinSync_r[p];
      end
    end
    assign pinRise[p] = pinSync_r[p] & ~pinPrev_r[p];
    assign pinFall[p] = ~pinSync_r[p] & pinPrev_r[p];
  end

  // ---------------------------------------------------------------
  // request flags
  logic [`PMVTR_NUM_VEC-2:0] srcFlag_r;
  logic [`PMVTR_NUM_VEC-2:0] srcFlag_nxt;
  logic [`PMVTR_NUM_MF-1:0] mfFlag_r;
  logic [`PMVTR_NUM_MF-1:0] mfFlag_nxt;
  logic [`PMVTR_NUM_VEC-2:0] srcSet;
  logic [`PMVTR_NUM_MF-1:0] mfSet;
  logic [`PMVTR_NUM_VEC-1:0] intReq;
  logic [`PMVTR_NUM_VEC-1:0] grant;
  logic [`PMVTR_ADDR_W-1:0] vector;
  logic takeInt;
  logic [1:0] extEdge;

  // active edge per external pin
  assign extEdge[0] = extFallEdge[0] ? pinFall[0] : pinRise[0];
  assign extEdge[1] = extFallEdge[1] ? pinFall[1] : pinRise[1];

  // set sources; shared slot 3 is the peripheral pin falling edge
  assign srcSet = {serXfer, tmr1Ovf, tmr0Ovf, extEdge[1], extEdge[0]};
  assign mfSet = mfEvent | ({{(`PMVTR_NUM_MF-1){1'b0}}, pinFall[2]} << 3);

  // pending and enabled requests
  assign intReq[`PMVTR_NUM_VEC-2:0] = srcFlag_r & intEn[`PMVTR_NUM_VEC-2:0];
  assign intReq[`PMVTR_NUM_VEC-1] = (|(mfFlag_r & mfEn)) & intEn[`PMVTR_NUM_VEC-1];

  pmvtr_vec_arb u_arb (
    .req(intReq),
    .grant(grant),
    .vector(vector)
  );

  // full stack holds the flag with no acknowledge; table read not broken
  assign takeInt = intAllowed & (|intReq) & ~stackFull & ~tblBusy
                 & ~tblReq.cur & ~tblReq.last;

  // flag next values: set wins over the acknowledge clear
  always_comb begin
    srcFlag_nxt = srcFlag_r;
    mfFlag_nxt = mfFlag_r;
    if (takeInt) begin
      srcFlag_nxt = srcFlag_r & ~grant[`PMVTR_NUM_VEC-2:0];
      if (grant[`PMVTR_NUM_VEC-1]) begin
        mfFlag_nxt = mfFlag_r & ~mfEn;
      end
    end
    srcFlag_nxt = srcFlag_nxt | srcSet;
    mfFlag_nxt = mfFlag_nxt | mfSet;
  end

  // flag registers
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      srcFlag_r <= '0;
      mfFlag_r <= '0;
    end else begin
      srcFlag_r <= srcFlag_nxt;
      mfFlag_r <= mfFlag_nxt;
    end
  end

  assign intFlags = {|mfFlag_r, srcFlag_r};
  assign mfFlags = mfFlag_r;

  // ---------------------------------------------------------------
  // program counter, acknowledge and push
  logic [`PMVTR_ADDR_W-1:0] pc_r;
  logic [`PMVTR_ADDR_W-1:0] pc_nxt;
  pmvtr_push_t push_r;
  pmvtr_push_t push_nxt;
  logic ack_r;
  logic ack_nxt;

  // acknowledge first, then branch, then step
  always_comb begin
    pc_nxt = pc_r;
    push_nxt = '0;
    ack_nxt = 1'b0;
    if (takeInt) begin
      push_nxt.push = 1'b1;
      push_nxt.data = pc_r;
      pc_nxt = vector;
      ack_nxt = 1'b1;
    end else if (coreBranch) begin
      pc_nxt = coreBranchAddr;
    end else if (coreAdvance) begin
      pc_nxt = pc_r + 14'h0001;
    end
  end

  // pc registers, start address after reset
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pc_r <= `PMVTR_RST_PC;
      push_r <= '0;
      ack_r <= 1'b0;
    end else begin
      pc_r <= pc_nxt;
      push_r <= push_nxt;
      ack_r <= ack_nxt;
    end
  end

  assign pc = pc_r;
  assign stackPush = push_r;
  assign intAck = ack_r;

  // ---------------------------------------------------------------
  // table read sequencer
  pmvtr_tstate_t tState_r;
  pmvtr_tstate_t tState_nxt;
  logic [7:0] tblPtr_r;
  logic [7:0] tblPtr_nxt;
  logic [7:0] tblHigh_r;
  logic [7:0] tblHigh_nxt;
  logic [7:0] tblDest_r;
  logic [7:0] tblDest_nxt;
  pmvtr_dm_wr_t dmWr_r;
  pmvtr_dm_wr_t dmWr_nxt;
  logic tblStart;
  logic [5:0] tblPage;
  logic [`PMVTR_ADDR_W-1:0] tblAddr;
  logic [`PMVTR_ADDR_W-1:0] memAddr;
  logic [`PMVTR_WORD_W-1:0] memData;

  assign tblStart = (tblReq.cur | tblReq.last) & (tState_r == TS_IDLE);
  assign tblPage = tblReq.last ? `PMVTR_LAST_PAGE : pc_r[13:8];
  assign tblAddr = {tblPage, tblPtr_r};
  assign memAddr = tblStart ? tblAddr : pc_r;

  pmvtr_prog_mem u_mem (
    .ref_clk(ref_clk),
    .wrEn(pgmWrEn),
    .wrAddr(pgmWrAddr),
    .wrData(pgmWrData),
    .rdAddr(memAddr),
    .rdData(memData)
  );

  assign instrWord = memData;
  assign tblBusy = (tState_r == TS_XFER);

  // avalon bus state
  logic avAck_r;
  logic avAck_nxt;
  logic [31:0] avData_r;
  logic [31:0] avData_nxt;
  logic avReq;
  logic avWrDone;

  assign avReq = avs_read | avs_write;
  assign avWrDone = avs_write & avAck_r;

  // sequencer next values
  always_comb begin
    tState_nxt = tState_r;
    tblHigh_nxt = tblHigh_r;
    tblDest_nxt = tblDest_r;
    dmWr_nxt = '0;
    unique case (tState_r)
      TS_IDLE: begin
        if (tblStart) begin
          tblDest_nxt = tblReq.dest;
          tState_nxt = TS_XFER;
        end
      end
      TS_XFER: begin
        dmWr_nxt.en = 1'b1;
        dmWr_nxt.addr = tblDest_r;
        dmWr_nxt.data = memData[7:0];
        tblHigh_nxt = memData[15:8];
        tState_nxt = TS_IDLE;
      end
      default: begin
        tState_nxt = TS_IDLE;
      end
    endcase
  end

  // pointer written only from the bus
  always_comb begin
    tblPtr_nxt = tblPtr_r;
    if (avWrDone && avs_address == `PMVTR_OFS_TBL_PTR) begin
      tblPtr_nxt = avs_writedata[7:0];
    end
  end

  // sequencer and table registers
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      tState_r <= TS_IDLE;
      tblPtr_r <= `PMVTR_RST_TBL_PTR;
      tblHigh_r <= `PMVTR_RST_TBL_HIGH;
      tblDest_r <= 8'h00;
      dmWr_r <= '0;
    end else begin
      tState_r <= tState_nxt;
      tblPtr_r <= tblPtr_nxt;
      tblHigh_r <= tblHigh_nxt;
      tblDest_r <= tblDest_nxt;
      dmWr_r <= dmWr_nxt;
    end
  end

  assign dmWr = dmWr_r;

  // ---------------------------------------------------------------
  // avalon slave: one wait cycle, then answer
  always_comb begin
    avAck_nxt = avReq & ~avAck_r;
    avData_nxt = 32'h0000_0000;
    if (avs_read && !avAck_r) begin
      unique case (avs_address)
        `PMVTR_OFS_TBL_PTR: avData_nxt = {24'h00_0000, tblPtr_r};
        `PMVTR_OFS_TBL_HIGH: avData_nxt = {24'h00_0000, tblHigh_r};
        `PMVTR_OFS_STATUS: begin
          avData_nxt[`PMVTR_ST_PC_LSB +: `PMVTR_ADDR_W] = pc_r;
          avData_nxt[`PMVTR_ST_REQ_LSB +: `PMVTR_NUM_VEC] = intFlags;
          avData_nxt[`PMVTR_ST_BUSY_BIT] = tblBusy;
        end
        default: avData_nxt = 32'h0000_0000; // unmapped reads zero
      endcase
    end else if (avAck_r) begin
      avData_nxt = avData_r;
    end
  end

  // bus registers
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      avAck_r <= 1'b0;
      avData_r <= 32'h0000_0000;
    end else begin
      avAck_r <= avAck_nxt;
      avData_r <= avData_nxt;
    end
  end

  assign avs_waitrequest = avReq & ~avAck_r;
  assign avs_readdata = avData_r;

endmodule // pmvtr_top

/* File: testbench/pmvtr_assertions.sv */
/*
  Concurrent checks on the ports of the vector and table-read block.
  Assumes a bind onto pmvtr_top from the bench top file.
*/
`include "pmvtr_defines.svh"
module pmvtr_assertions
  import pmvtr_pkg::*;
(
  input wire logic ref_clk, // clock
  input wire logic sys_rst, // reset
  input wire logic avs_read, // bus read
  input wire logic avs_waitrequest, // bus stall
  input wire logic [13:0] pc, // program counter
  input wire pmvtr_tbl_req_t tblReq, // table request
  input wire logic tblBusy, // second cycle
  input wire pmvtr_dm_wr_t dmWr, // low-byte write
  input wire logic stackFull, // stack full
  input wire pmvtr_push_t stackPush, // push
  input wire logic intAck, // acknowledge
  input wire logic [5:0] intEn, // enables
  input wire logic [5:0] intFlags // flags
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  logic tblGo;
  // accepted table request
  assign tblGo = (tblReq.cur | tblReq.last) & ~tblBusy;

  AST_TBL_BUSY: assert property (tblGo |=> tblBusy ##1 !tblBusy)
    else $error("table busy cycle wrong");
  AST_TBL_WR: assert property (tblGo |=> ##1 dmWr.en && dmWr.addr == $past(tblReq.dest, 2))
    else $error("table low byte write missing");
  AST_WR_CAUSE: assert property (dmWr.en |-> $past(tblBusy))
    else $error("stray low byte write");
  AST_ACK_PUSH: assert property (intAck |-> stackPush.push && stackPush.data == $past(pc))
    else $error("push missing or wrong");
  AST_PUSH_ACK: assert property (stackPush.push |-> intAck)
    else $error("push without acknowledge");
  AST_VEC_EXT0: assert property (intAck && $past(intFlags[0] & intEn[0]) |-> pc == `PMVTR_VEC_EXT0)
    else $error("wrong entry for ext 0");
  AST_VEC_TMR0: assert property (intAck && $past(intFlags[2:0] & intEn[2:0]) == 3'h4
    |-> pc == `PMVTR_VEC_TMR0)
    else $error("wrong entry for timer 0");
  AST_FULL_NOACK: assert property (stackFull |=> !intAck)
    else $error("acknowledge with full stack");
  AST_FLAG_KEEP: assert property (stackFull && intFlags[3] |=> intFlags[3])
    else $error("flag lost while stack full");
  AST_AVS_WAIT: assert property ($rose(avs_read) |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("bus answer timing wrong");
endmodule // pmvtr_assertions

/* File: testbench/pmvtr_core_model.sv */
/*
  Core-side model: return stack level and interrupt permission.
  Assumes the bench pops the stack through popReq.
*/
module pmvtr_core_model
  import pmvtr_pkg::*;
#(
  parameter int DEPTH = 1
)
(
  input wire logic ref_clk, // clock
  input wire logic sys_rst, // reset
  input wire pmvtr_push_t stackPush, // push from block
  input wire logic popReq, // return executed
  input wire logic allowIn, // master enable
  input wire pmvtr_tbl_req_t tblReq, // table request
  output logic intAllowed, // may take interrupt
  output logic stackFull // stack full
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] lvl;
  // stack level follows pushes and pops
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      lvl <= 4'h0;
    end else begin
      lvl <= lvl + 4'(stackPush.push) - 4'(popReq && lvl != 4'h0);
    end
  end
  // a push in flight already takes its level, so no second acknowledge
  assign stackFull = ((lvl + 4'(stackPush.push)) >= 4'(DEPTH));
  // interrupts held off around table reads
  assign intAllowed = allowIn & ~(tblReq.cur | tblReq.last);
endmodule // pmvtr_core_model

/* File: testbench/tb.sv */
/*
  Self-checking bench for pmvtr_top with the core model.
  Assumes a one-level return stack and a 125 MHz clock.
*/
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import pmvtr_pkg::*;
  logic ref_clk = 1'h0;
  logic sys_rst = 1'h1;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'h0, avs_write = 1'h0, avs_waitrequest;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, rd;
  logic pgmWrEn = 1'h0, coreAdvance = 1'h0, coreBranch = 1'h0;
  logic [13:0] pgmWrAddr = 14'h0, coreBranchAddr = 14'h0, pc;
  logic [15:0] pgmWrData = 16'h0, instrWord;
  pmvtr_tbl_req_t tblReq = '0;
  pmvtr_dm_wr_t dmWr;
  pmvtr_push_t stackPush;
  logic tblBusy, intAck, intAllowed, stackFull, popReq = 1'h0, allowIn = 1'h0;
  logic [1:0] extIntPin = 2'h0, extFallEdge = 2'h0;
  logic periphIntPin = 1'h1, tmr0Ovf = 1'h0, tmr1Ovf = 1'h0, serXfer = 1'h0;
  logic [5:0] mfEvent = 6'h0, intEn = 6'h3F, mfEn = 6'h3F, intFlags, mfFlags;
  int num_errors = 0;
  int total_checks = 0;

  always #4 ref_clk = ~ref_clk;

  pmvtr_top uut (.ref_clk, .sys_rst, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_readdata, .avs_waitrequest, .pgmWrEn, .pgmWrAddr,
    .pgmWrData, .coreAdvance, .coreBranch, .coreBranchAddr, .pc, .instrWord,
    .tblReq, .tblBusy, .dmWr, .extIntPin, .extFallEdge, .periphIntPin,
    .tmr0Ovf, .tmr1Ovf, .serXfer, .mfEvent, .intEn, .mfEn, .intAllowed,
    .stackFull, .stackPush, .intAck, .intFlags, .mfFlags);

  pmvtr_core_model #(.DEPTH(1)) core (.ref_clk, .sys_rst, .stackPush, .popReq,
    .allowIn, .tblReq, .intAllowed, .stackFull);

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask

  // one bus cycle, held until waitrequest is sampled low
  task automatic avs(input logic wr, input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= ~wr;
    do begin
      @(posedge ref_clk);
    end while (avs_waitrequest !== 1'h0);
    rd = avs_readdata;
    avs_write <= 1'h0;
    avs_read <= 1'h0;
  endtask

  task automatic ld(input logic [13:0] a, input logic [15:0] w);
    @(posedge ref_clk);
    pgmWrEn <= 1'h1;
    pgmWrAddr <= a;
    pgmWrData <= w;
    @(posedge ref_clk);
    pgmWrEn <= 1'h0;
  endtask

  task automatic br(input logic [13:0] a);
    @(posedge ref_clk);
    coreBranch <= 1'h1;
    coreBranchAddr <= a;
    @(posedge ref_clk);
    coreBranch <= 1'h0;
  endtask

  // table read, request held into the busy cycle
  task automatic tbl(input logic last, input logic [7:0] dest, input logic [15:0] w);
    @(posedge ref_clk);
    tblReq <= '{cur: ~last, last: last, dest: dest};
    @(posedge ref_clk);
    #1 check(32'(tblBusy), 32'h1);
    check(32'(instrWord), 32'(w));
    @(posedge ref_clk);
    tblReq <= '0;
    #1 check(32'(dmWr), {15'h0, 1'h1, dest, w[7:0]});
    @(posedge ref_clk);
    #1 check(32'(dmWr.en), 32'h0);
    avs(1'h0, 4'h4, 32'h0);
    check(rd, {24'h0, w[15:8]});
  endtask

  task automatic wait_ack();
    int n;
    n = 0;
    while (intAck !== 1'h1 && n < 20) begin
      @(posedge ref_clk);
      #1 n++;
    end
  endtask

  task automatic pop();
    @(posedge ref_clk);
    popReq <= 1'h1;
    @(posedge ref_clk);
    popReq <= 1'h0;
  endtask

  task automatic test_reset();
    @(posedge ref_clk);
    #1 check(32'(pc), 32'h0);
    @(posedge ref_clk);
    coreAdvance <= 1'h1;
    @(posedge ref_clk);
    coreAdvance <= 1'h0;
    #1 check(32'(pc), 32'h1);
    avs(1'h0, 4'h0, 32'h0);
    check(rd, 32'h0);
    $display("reset test done");
  endtask

  task automatic test_table();
    ld(14'h3F06, 16'hA51A);
    ld(14'h1206, 16'h5AC3);
    avs(1'h1, 4'h0, 32'h106);
    tbl(1'h1, 8'h20, 16'hA51A);
    br(14'h1234);
    tbl(1'h0, 8'h21, 16'h5AC3);
    avs(1'h0, 4'h0, 32'h0);
    check(rd, 32'h06);
    $display("table test done");
  endtask

  task automatic test_ro();
    avs(1'h1, 4'h4, 32'hFF);
    avs(1'h0, 4'h4, 32'h0);
    check(rd, 32'h5A);
    avs(1'h1, 4'hC, 32'hFF);
    avs(1'h0, 4'hC, 32'h0);
    check(rd, 32'h0);
    $display("read-only test done");
  endtask

  task automatic test_vectors();
    allowIn <= 1'h1;
    for (int i = 0; i < 6; i++) begin
      @(posedge ref_clk);
      case (i)
        0: extIntPin[0] <= 1'h1;
        1: extIntPin[1] <= 1'h1;
        2: tmr0Ovf <= 1'h1;
        3: tmr1Ovf <= 1'h1;
        4: serXfer <= 1'h1;
        default: periphIntPin <= 1'h0;
      endcase
      @(posedge ref_clk);
      {tmr0Ovf, tmr1Ovf, serXfer} <= 3'h0;
      wait_ack();
      check(32'(pc), 32'(4 * (i + 1)));
      pop();
    end
    @(posedge ref_clk);
    extFallEdge[0] <= 1'h1;
    extIntPin[0] <= 1'h0;
    wait_ack();
    check(32'(pc), 32'h4);
    pop();
    $display("vector test done");
  endtask

  task automatic test_prio();
    int acks;
    acks = 0;
    allowIn <= 1'h0;
    @(posedge ref_clk);
    {tmr0Ovf, tmr1Ovf} <= 2'h3;
    mfEvent <= 6'h04;
    @(posedge ref_clk);
    {tmr0Ovf, tmr1Ovf} <= 2'h0;
    mfEvent <= 6'h00;
    repeat (3) @(posedge ref_clk);
    check(32'(mfFlags), 32'h04);
    allowIn <= 1'h1;
    wait_ack();
    check(32'(pc), 32'hC);
    repeat (10) begin
      @(posedge ref_clk);
      #1 acks += int'(intAck === 1'h1);
    end
    check(32'(acks), 32'h0);
    avs(1'h0, 4'h8, 32'h0);
    check(rd, {10'h0, 6'h28, 2'h0, 14'h00C});
    pop();
    wait_ack();
    check(32'(pc), 32'h10);
    pop();
    wait_ack();
    check(32'(pc), 32'h18);
    pop();
    $display("priority test done");
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    repeat (8) @(posedge ref_clk);
    sys_rst <= 1'h0;
    test_reset();
    test_table();
    test_ro();
    test_vectors();
    test_prio();
    summarize();
  end

  // watchdog
  initial begin
    #20000;
    num_errors++;
    $display("unexpected at %0t: timeout", $time);
    summarize();
  end
endmodule // tb

bind pmvtr_top pmvtr_assertions chk (.ref_clk, .sys_rst, .avs_read, .avs_waitrequest,
  .pc, .tblReq, .tblBusy, .dmWr, .stackFull, .stackPush, .intAck, .intEn, .intFlags);
